// ### core/itm_top.sv
// Purpose: intrusive self-test mode control of an isolated gate driver
// Assumes: sys_clk 20 MHz; spi, pwm and sense pins are asynchronous
// Notes:   spi is receive only; frame ends on chip select release
`include "itm_defs.svh"
module itm_top
  import itm_pkg::*;
#(
  parameter int TMO_CYC   = `ITM_MODE_TMO_CYC,
  parameter int BLANK_CYC = `ITM_BLANK_CYC
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // spi link pins
  input  wire logic spi_sclk,
  input  wire logic spi_cs_n,
  input  wire logic spi_mosi,
  // pwm and sense pins
  input  wire logic pwm_input,
  input  wire logic desat_sense_above,
  input  wire logic secondary_supply_low_threshold,
  input  wire logic digital_supply_ok,
  // configuration and flag clears
  input  wire logic parity_check_en,
  input  wire logic spi_err_clr,
  input  wire logic desat_err_clr,
  // status
  output itm_mode_t op_mode,
  output logic      test_unlocked,
  output logic      spi_command_error_flag,
  output logic      desat_error_flag,
  // output stage and supervision controls
  output itm_gate_t turn_on_gate_output,
  output itm_test_t test_ctrl,
  output logic      gate_high_mon_en,
  output logic      outstage_mon_en,
  // open-drain undervoltage notification pin
  output logic      secondary_undervoltage_notify_n_lvl,
  output logic      secondary_undervoltage_notify_n_en
);

  localparam int TMO_W   = $clog2(TMO_CYC + 1);
  localparam int BLANK_W = $clog2(BLANK_CYC + 1);
  localparam logic [TMO_W-1:0]   TMO_LAST  = TMO_W'(TMO_CYC - 1);
  localparam logic [BLANK_W-1:0] BLANK_END = BLANK_W'(BLANK_CYC);
  localparam logic [`ITM_CNT_W-1:0] FRAME_LEN =
    `ITM_CNT_W'(`ITM_FRAME_BITS);

  typedef struct packed {
    itm_mode_t                  mode;
    itm_unlock_t                unlock;
    itm_sel_t                   shadow;
    itm_sel_t                   act;
    logic [`ITM_LVL_W-1:0]      weak_lvl;
    logic                       vbec;
    logic                       sclk_d;
    logic                       cs_d;
    logic [`ITM_CNT_W-1:0]      bit_cnt;
    logic [`ITM_FRAME_BITS-1:0] shreg;
    logic                       spi_err;
    logic [TMO_W-1:0]           tmo;
    logic [BLANK_W-1:0]         blank;
    logic                       desat_err;
    itm_gate_t                  gate;
    itm_test_t                  test;
    logic                       mon_en;
    logic                       nuv_en;
  } itm_top_st_t;

  localparam itm_top_st_t ST_RST = '{
    mode:     M_OFF,
    unlock:   U_NONE,
    weak_lvl: `ITM_RST_WEAK_LVL,
    vbec:     `ITM_RST_VBEC,
    cs_d:     `ITM_RST_CS_N,
    mon_en:   `ITM_RST_MON_EN,
    default:  '0
  };

  itm_top_st_t st_ff;
  itm_top_st_t nxt_st;

  logic [6:0] pin_s;
  logic       sclk_s;
  logic       cs_s;
  logic       mosi_s;
  logic       pwm_s;
  logic       desat_s;
  logic       uv_s;
  logic       dok_s;
  itm_frame_t frm;
  logic       sclk_rise;
  logic       frame_done;
  logic       len_ok;
  logic       op_ok;
  logic       par_ok;
  logic       frame_ok;
  logic       in_test;
  logic       is_weak;
  logic       blk_pwm;
  logic       force_d1;
  logic       ton_cmd;
  logic       desat_hit;

  itm_sync #(
    .W   (7),
    .RST (`ITM_SYNC_RST)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .async_i ({digital_supply_ok, secondary_supply_low_threshold,
               desat_sense_above, pwm_input, spi_mosi, spi_cs_n,
               spi_sclk}),
    .sync_o  (pin_s)
  );

  assign {dok_s, uv_s, desat_s, pwm_s, mosi_s, cs_s, sclk_s} = pin_s;

  // frame checks
  assign frm        = itm_frame_t'(st_ff.shreg);
  assign sclk_rise  = sclk_s && !st_ff.sclk_d;
  assign frame_done = cs_s && !st_ff.cs_d;
  assign len_ok     = st_ff.bit_cnt == FRAME_LEN;
  assign op_ok      = frm.op <= `ITM_OP_LAST;
  assign par_ok     = ^st_ff.shreg;
  // parity term drops out when disabled, length and opcode stay
  assign frame_ok   = len_ok && op_ok && (par_ok || !parity_check_en);

  // test mode qualifiers
  assign in_test  = st_ff.mode inside {M_VERIFY, M_WEAK};
  assign is_weak  = st_ff.mode == M_WEAK;
  assign blk_pwm  = st_ff.act.sec inside {`ITM_SEC_DESAT2, `ITM_SEC_DESAT3,
                                          `ITM_SEC_OCP3};
  assign force_d1 = is_weak && st_ff.act.sec == `ITM_SEC_DESAT1;
  assign ton_cmd  = (st_ff.mode == M_ACTIVE || is_weak) && pwm_s;
  // level two relies on the real sense pin after blanking
  assign desat_hit = (ton_cmd && st_ff.blank == BLANK_END &&
                      (desat_s || force_d1)) ||
                     (is_weak && st_ff.act.sec == `ITM_SEC_DESAT3);

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.sclk_d = sclk_s;
    nxt_st.cs_d   = cs_s;

    // receive shifter
    if (st_ff.cs_d && !cs_s) begin
      nxt_st.bit_cnt = '0;
    end
    if (!cs_s && sclk_rise) begin
      nxt_st.shreg = {st_ff.shreg[`ITM_FRAME_BITS-2:0], mosi_s};
      if (st_ff.bit_cnt != '1) begin
        nxt_st.bit_cnt = st_ff.bit_cnt + 1'b1;
      end
    end

    // error flag: a new error in the clear cycle is kept
    if (spi_err_clr) begin
      nxt_st.spi_err = 1'b0;
    end
    if (frame_done && !frame_ok) begin
      nxt_st.spi_err = 1'b1;
    end

    // command execution
    if (frame_done && frame_ok) begin
      case (frm.op)
        `ITM_OP_ENTER_CFG: begin
          if (st_ff.mode == M_OFF) begin
            nxt_st.mode = M_CFG;
          end
        end
        `ITM_OP_EXIT: begin
          nxt_st.mode = M_OFF;
        end
        `ITM_OP_ENTER_ACT: begin
          // going active withdraws any unlock
          if (st_ff.mode inside {M_OFF, M_CFG}) begin
            nxt_st.mode   = M_ACTIVE;
            nxt_st.unlock = U_NONE;
          end
        end
        `ITM_OP_UNLOCK: begin
          if (st_ff.mode == M_CFG) begin
            if (st_ff.unlock == U_NONE && frm.dat == `ITM_KEY_1) begin
              nxt_st.unlock = U_STEP;
            end else if (st_ff.unlock == U_STEP &&
                         frm.dat == `ITM_KEY_2) begin
              nxt_st.unlock = U_OPEN;
            end else begin
              nxt_st.unlock = U_NONE;
            end
          end
        end
        `ITM_OP_ENTER_VER: begin
          // only reachable from config, never from active
          if (st_ff.mode == M_CFG && st_ff.unlock == U_OPEN) begin
            nxt_st.mode = M_VERIFY;
            nxt_st.act  = st_ff.shadow;
            nxt_st.tmo  = '0;
          end
        end
        `ITM_OP_ENTER_WK: begin
          if (st_ff.mode == M_VERIFY) begin
            nxt_st.mode = M_WEAK;
          end
        end
        `ITM_OP_WR_PSEL: begin
          if (st_ff.mode == M_CFG) begin
            nxt_st.shadow.pri = frm.dat[`ITM_PRI_W-1:0];
          end
        end
        `ITM_OP_WR_SSEL: begin
          if (st_ff.mode == M_CFG) begin
            nxt_st.shadow.sec = frm.dat[`ITM_SEC_W-1:0];
          end
        end
        `ITM_OP_WR_WEAK: begin
          if (st_ff.mode == M_CFG) begin
            nxt_st.weak_lvl = frm.dat[`ITM_LVL_W-1:0];
            nxt_st.vbec     = frm.dat[`ITM_VBEC_BIT];
          end
        end
        default: begin
        end
      endcase
    end

    // fixed time-out, not reachable by software
    if (in_test) begin
      nxt_st.tmo = st_ff.tmo + 1'b1;
      if (st_ff.tmo == TMO_LAST) begin
        nxt_st.mode = M_OFF;
      end
    end
    if (!(nxt_st.mode inside {M_VERIFY, M_WEAK})) begin
      nxt_st.act = '0;
    end

    // output stage
    nxt_st.gate = '0;
    if (st_ff.mode == M_ACTIVE && pwm_s && !st_ff.desat_err) begin
      nxt_st.gate.on    = 1'b1;
      nxt_st.gate.level = `ITM_FULL_LVL;
    end else if (is_weak && pwm_s && !blk_pwm && !st_ff.desat_err) begin
      nxt_st.gate.on      = 1'b1;
      nxt_st.gate.level   = st_ff.weak_lvl;
      nxt_st.gate.vbe_sub = st_ff.vbec;
    end

    // blanking runs on the command, so level two still detects
    if (!ton_cmd) begin
      nxt_st.blank = '0;
    end else if (st_ff.blank != BLANK_END) begin
      nxt_st.blank = st_ff.blank + 1'b1;
    end
    if (desat_err_clr) begin
      nxt_st.desat_err = 1'b0;
    end
    if (desat_hit) begin
      nxt_st.desat_err = 1'b1;
    end

    // supervision controls gated by the test modes; notify enable follows the supplies
    nxt_st.test.force_desat = in_test &&
      st_ff.act.sec inside {`ITM_SEC_DESAT1, `ITM_SEC_DESAT3};
    nxt_st.test.force_ocp = in_test &&
      st_ff.act.sec inside {`ITM_SEC_OCP1, `ITM_SEC_OCP3};
    nxt_st.test.supply  = in_test && st_ff.act.sec == `ITM_SEC_SUPPLY;
    nxt_st.test.clk_sup = in_test && st_ff.act.pri == `ITM_PRI_CLK;
    nxt_st.test.tcf     = in_test && st_ff.act.pri == `ITM_PRI_TCF;
    nxt_st.mon_en       = !in_test;
    nxt_st.nuv_en       = uv_s || !dok_s;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign op_mode                             = st_ff.mode;
  assign test_unlocked                       = st_ff.unlock == U_OPEN;
  assign spi_command_error_flag              = st_ff.spi_err;
  assign desat_error_flag                    = st_ff.desat_err;
  assign turn_on_gate_output                 = st_ff.gate;
  assign test_ctrl                           = st_ff.test;
  assign gate_high_mon_en                    = st_ff.mon_en;
  assign outstage_mon_en                     = st_ff.mon_en;
  assign secondary_undervoltage_notify_n_lvl = 1'b0;
  assign secondary_undervoltage_notify_n_en  = st_ff.nuv_en;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_spi_err_set;
    frame_done && !frame_ok |=> spi_command_error_flag;
  endproperty
  a_spi_err_set: assert property (p_spi_err_set)
    else $error("bad frame did not set spi error");

  property p_parity_off;
    frame_done && len_ok && op_ok && !par_ok && !parity_check_en &&
      !st_ff.spi_err |=> !spi_command_error_flag;
  endproperty
  a_parity_off: assert property (p_parity_off)
    else $error("parity error flagged while parity disabled");

  property p_notify;
    1'b1 |=> secondary_undervoltage_notify_n_en ==
      ($past(uv_s) || !$past(dok_s));
  endproperty
  a_notify: assert property (p_notify)
    else $error("notify pin does not follow supply state");

  property p_locked;
    st_ff.mode != M_VERIFY && st_ff.unlock != U_OPEN |=>
      st_ff.mode != M_VERIFY;
  endproperty
  a_locked: assert property (p_locked)
    else $error("verification entered without unlock");

  property p_active_quiet;
    st_ff.mode == M_ACTIVE |=> test_ctrl == '0 && st_ff.mode != M_VERIFY;
  endproperty
  a_active_quiet: assert property (p_active_quiet)
    else $error("test function reachable from active mode");

  property p_timeout;
    in_test && st_ff.tmo == TMO_LAST |=> op_mode == M_OFF;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("test mode survived its time-out");

  property p_tmo_restart;
    st_ff.mode == M_CFG ##1 st_ff.mode == M_VERIFY |->
      st_ff.tmo == '0 ##1 st_ff.tmo == TMO_W'(1);
  endproperty
  a_tmo_restart: assert property (p_tmo_restart)
    else $error("time-out count not restarted on entry");

  property p_sel_apply;
    st_ff.mode == M_CFG ##1 st_ff.mode == M_VERIFY |->
      st_ff.act == $past(st_ff.shadow);
  endproperty
  a_sel_apply: assert property (p_sel_apply)
    else $error("selection not applied on verification entry");

  property p_mon_off;
    in_test |=> !gate_high_mon_en && !outstage_mon_en;
  endproperty
  a_mon_off: assert property (p_mon_off)
    else $error("monitoring left on in test mode");

  property p_weak_on;
    is_weak && pwm_s && !blk_pwm && !st_ff.desat_err |=>
      turn_on_gate_output.on &&
      turn_on_gate_output.level == $past(st_ff.weak_lvl);
  endproperty
  a_weak_on: assert property (p_weak_on)
    else $error("weak turn-on level wrong");

  property p_vbe;
    turn_on_gate_output.on && $past(is_weak) |->
      turn_on_gate_output.vbe_sub == $past(st_ff.vbec);
  endproperty
  a_vbe: assert property (p_vbe)
    else $error("booster compensation not applied");

  property p_d1_err;
    force_d1 && ton_cmd && st_ff.blank == BLANK_END |=>
      desat_error_flag ##1 !turn_on_gate_output.on;
  endproperty
  a_d1_err: assert property (p_d1_err)
    else $error("desat test one gave no error after blanking");

  property p_d1_pass;
    force_d1 && pwm_s && !st_ff.desat_err |=> turn_on_gate_output.on;
  endproperty
  a_d1_pass: assert property (p_d1_pass)
    else $error("desat test one did not pass pwm through");

  property p_d2_block;
    is_weak && st_ff.act.sec == `ITM_SEC_DESAT2 |=>
      !turn_on_gate_output.on;
  endproperty
  a_d2_block: assert property (p_d2_block)
    else $error("desat test two forwarded pwm");

endmodule

// ### core/itm_defs.svh
// Purpose: constants of the intrusive test mode control block
// Assumes: sys_clk at 20 MHz; spi frames of 16 bits, msb first
// Notes:   frame layout is opcode, data, odd parity bit
//
// Summary of operation
// - every received spi frame is checked; a bad one sets the spi error flag
// - parity checking can be switched off; length and opcode checks remain
// - no intrusive test starts before the unlock command sequence after reset
// - no intrusive test can start while the device is normally active
// - a fixed hardware time-out returns verification or weak mode to off
// - selections written in config mode take effect on entering verification
// - gate high monitoring and output stage monitoring are off in test modes
// - desaturation tests run only in verification or weak mode
// - desat test one forces comparator high; error follows turn-on blanking
// - desat test one passes the pwm input through as a weak turn-on
// - desat test two: no output action, detection stays normal after blanking
// - desat test two never forwards the pwm input to the output stage
// - test modes support weak-on, desat, ocp, supply, clock and timing tests
`ifndef ITM_DEFS_SVH
`define ITM_DEFS_SVH

// timing
`define ITM_CLK_PERIOD_NS 50
`define ITM_BLANK_NS      1000
`define ITM_BLANK_CYC     ((`ITM_BLANK_NS + `ITM_CLK_PERIOD_NS - 1) / `ITM_CLK_PERIOD_NS)
`define ITM_MODE_TMO_US   10000
`define ITM_MODE_TMO_CYC  (`ITM_MODE_TMO_US * 1000 / `ITM_CLK_PERIOD_NS)

// frame layout
`define ITM_FRAME_BITS 16
`define ITM_CNT_W      5
`define ITM_OP_W       4
`define ITM_DAT_W      11
`define ITM_PRI_W      2
`define ITM_SEC_W      3
`define ITM_LVL_W      4
`define ITM_VBEC_BIT   4

// opcodes
`define ITM_OP_NOP       4'h0
`define ITM_OP_ENTER_CFG 4'h1
`define ITM_OP_EXIT      4'h2
`define ITM_OP_ENTER_ACT 4'h3
`define ITM_OP_UNLOCK    4'h4
`define ITM_OP_ENTER_VER 4'h5
`define ITM_OP_ENTER_WK  4'h6
`define ITM_OP_WR_PSEL   4'h7
`define ITM_OP_WR_SSEL   4'h8
`define ITM_OP_WR_WEAK   4'h9
`define ITM_OP_LAST      4'h9

// unlock keys
`define ITM_KEY_1 11'h2A5
`define ITM_KEY_2 11'h15A

// primary selection codes
`define ITM_PRI_NONE 2'h0
`define ITM_PRI_CLK  2'h1
`define ITM_PRI_TCF  2'h2

// secondary selection codes
`define ITM_SEC_NONE   3'h0
`define ITM_SEC_DESAT1 3'h1
`define ITM_SEC_DESAT2 3'h2
`define ITM_SEC_DESAT3 3'h3
`define ITM_SEC_OCP1   3'h4
`define ITM_SEC_OCP3   3'h5
`define ITM_SEC_SUPPLY 3'h6

// levels and reset values
`define ITM_FULL_LVL     4'hF
`define ITM_RST_WEAK_LVL 4'h0
`define ITM_RST_VBEC     1'b0
`define ITM_RST_MON_EN   1'b1
`define ITM_RST_CS_N     1'b1
`define ITM_SYNC_RST     7'h42

`endif

// ### core/itm_pkg.sv
// Purpose: types of the intrusive test mode control block
// Assumes: itm_defs.svh supplies widths
// Notes:   selection codes keep one function per side by construction
`include "itm_defs.svh"
package itm_pkg;

  typedef enum logic [2:0] {
    M_OFF,
    M_CFG,
    M_ACTIVE,
    M_VERIFY,
    M_WEAK
  } itm_mode_t;

  typedef enum logic [1:0] {
    U_NONE,
    U_STEP,
    U_OPEN
  } itm_unlock_t;

  typedef struct packed {
    logic [`ITM_OP_W-1:0]  op;
    logic [`ITM_DAT_W-1:0] dat;
    logic                  par;
  } itm_frame_t;

  typedef struct packed {
    logic [`ITM_PRI_W-1:0] pri;
    logic [`ITM_SEC_W-1:0] sec;
  } itm_sel_t;

  typedef struct packed {
    logic                  on;
    logic [`ITM_LVL_W-1:0] level;
    logic                  vbe_sub;
  } itm_gate_t;

  typedef struct packed {
    logic force_desat;
    logic force_ocp;
    logic supply;
    logic clk_sup;
    logic tcf;
  } itm_test_t;

endpackage

// ### core/itm_sync.sv
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
module itm_sync #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // levels
  input  wire logic [W-1:0] async_i,
  output      logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } itm_sync_st_t;

  itm_sync_st_t st_ff;
  itm_sync_st_t nxt_st;

  always_comb begin
    nxt_st.s1 = async_i;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= {RST, RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_o = st_ff.s2;

endmodule

// ### dv/itm_host.sv
// Purpose: host model driving the spi link and the pwm pin
// Assumes: sys_clk 20 MHz; link clock 400 ns, idle low between frames
// Notes:   a released data line shows the inverse of its last bit
`include "itm_defs.svh"
module itm_host (
  // clock
  input  wire logic sys_clk,
  // link pins
  output      logic spi_sclk,
  output      logic spi_cs_n,
  output      logic spi_mosi,
  // pwm pin
  output      logic pwm_input
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    spi_sclk  <= 1'b0;
    spi_cs_n  <= `ITM_RST_CS_N;
    spi_mosi  <= 1'b0;
    pwm_input <= 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // four cycles a level keeps clear of the three-cycle sampling minimum
  task automatic send(input logic [31:0] bits, input int nbits);
    spi_cs_n <= 1'b0;
    wait_clk(4);
    for (int i = nbits - 1; i >= 0; i--) begin
      spi_mosi <= bits[i];
      wait_clk(4);
      spi_sclk <= 1'b1;
      wait_clk(4);
      spi_sclk <= 1'b0;
    end
    wait_clk(4);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi;
    // answer lands three edges after release; wait past it
    wait_clk(8);
  endtask

  task automatic set_pwm(input logic v);
    pwm_input <= v;
  endtask
endmodule

// ### dv/itm_top_tb.sv
// Purpose: self-checking bench of the intrusive test mode control
// Assumes: host model drives link and pwm; sense and supply pins from here
// Notes:   time-out and blanking shortened through parameters
`include "itm_defs.svh"
module itm_top_tb
  import itm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int TMO   = 2000;
  localparam int BLANK = 4;
  localparam logic [1:0] PT [5] = '{`ITM_PRI_NONE, `ITM_PRI_NONE,
    `ITM_PRI_NONE, `ITM_PRI_CLK, `ITM_PRI_TCF};
  localparam logic [2:0] ST [5] = '{`ITM_SEC_DESAT1, `ITM_SEC_OCP1,
    `ITM_SEC_SUPPLY, `ITM_SEC_NONE, `ITM_SEC_NONE};
  localparam logic [4:0] ET [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};

  logic      sys_clk;
  logic      rst_n;
  logic      spi_sclk;
  logic      spi_cs_n;
  logic      spi_mosi;
  logic      pwm_input;
  logic      desat_sense_above;
  logic      uv;
  logic      dok;
  logic      parity_check_en;
  logic      spi_err_clr;
  logic      desat_err_clr;
  itm_mode_t op_mode;
  logic      test_unlocked;
  logic      spi_err;
  logic      desat_err;
  itm_gate_t gate;
  itm_test_t test_ctrl;
  logic      gh_mon;
  logic      os_mon;
  logic      nfy_lvl;
  logic      nfy_en;
  int        err_count;
  int        num_checks;

  itm_host host (
    .sys_clk  (sys_clk),
    .spi_sclk (spi_sclk),
    .spi_cs_n (spi_cs_n),
    .spi_mosi (spi_mosi),
    .pwm_input(pwm_input)
  );

  itm_top #(.TMO_CYC(TMO), .BLANK_CYC(BLANK)) dut (
    .sys_clk                            (sys_clk),
    .rst_n                              (rst_n),
    .spi_sclk                           (spi_sclk),
    .spi_cs_n                           (spi_cs_n),
    .spi_mosi                           (spi_mosi),
    .pwm_input                          (pwm_input),
    .desat_sense_above                  (desat_sense_above),
    .secondary_supply_low_threshold     (uv),
    .digital_supply_ok                  (dok),
    .parity_check_en                    (parity_check_en),
    .spi_err_clr                        (spi_err_clr),
    .desat_err_clr                      (desat_err_clr),
    .op_mode                            (op_mode),
    .test_unlocked                      (test_unlocked),
    .spi_command_error_flag             (spi_err),
    .desat_error_flag                   (desat_err),
    .turn_on_gate_output                (gate),
    .test_ctrl                          (test_ctrl),
    .gate_high_mon_en                   (gh_mon),
    .outstage_mon_en                    (os_mon),
    .secondary_undervoltage_notify_n_lvl(nfy_lvl),
    .secondary_undervoltage_notify_n_en (nfy_en)
  );

  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  task automatic print_verdict();
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // odd parity over the whole word
  function automatic logic [31:0] frame(logic [3:0] op, logic [10:0] d);
    return {16'h0000, op, d, ~(^{op, d})};
  endfunction

  task automatic cmd(input logic [3:0] op, input logic [10:0] d = 11'h000);
    host.send(frame(op, d), 16);
  endtask

  task automatic unlock();
    cmd(`ITM_OP_ENTER_CFG);
    // a stray key frame drops an unlock left over from an earlier pass
    cmd(`ITM_OP_UNLOCK);
    cmd(`ITM_OP_UNLOCK, `ITM_KEY_1);
    cmd(`ITM_OP_UNLOCK, `ITM_KEY_2);
    chk("unlocked", 8'(test_unlocked), 8'h01);
  endtask

  task automatic wait_mode(input itm_mode_t m, output int n);
    n = 0;
    while (op_mode !== m) begin
      clk(1);
      n++;
      if (n > 2 * TMO) begin
        err_count++;
        print_verdict();
      end
    end
  endtask

  task automatic clr_spi();
    spi_err_clr <= 1'b1;
    clk(1);
    spi_err_clr <= 1'b0;
    clk(1);
    chk("spi_clr", 8'(spi_err), 8'h00);
  endtask

  task automatic t_reset();
    chk("rst_mode", 8'(op_mode), 8'(M_OFF));
    chk("rst_flags", 8'({test_unlocked, spi_err, desat_err}), 8'h00);
    chk("rst_gate", 8'(gate), 8'h00);
    chk("rst_mon", 8'({gh_mon, os_mon}), 8'h03);
    chk("rst_nfy", 8'({nfy_en, nfy_lvl}), 8'h00);
  endtask

  task automatic t_notify();
    uv <= 1'b1;
    clk(4);
    chk("uv_nfy", 8'({nfy_en, nfy_lvl}), 8'h02);
    uv  <= 1'b0;
    dok <= 1'b0;
    clk(4);
    chk("dok_nfy", 8'({nfy_en, nfy_lvl}), 8'h02);
    dok <= 1'b1;
    clk(4);
    chk("ok_nfy", 8'({nfy_en, nfy_lvl}), 8'h00);
  endtask

  task automatic t_spi_err();
    host.send(frame(`ITM_OP_ENTER_CFG, 11'h000) ^ 32'h1, 16);
    chk("par_err", 8'(spi_err), 8'h01);
    chk("par_mode", 8'(op_mode), 8'(M_OFF));
    clr_spi();
    parity_check_en <= 1'b0;
    host.send(frame(`ITM_OP_ENTER_CFG, 11'h000) ^ 32'h1, 16);
    chk("nopar_err", 8'(spi_err), 8'h00);
    chk("nopar_mode", 8'(op_mode), 8'(M_CFG));
    host.send(frame(`ITM_OP_NOP, 11'h000), 15);
    chk("len_err", 8'(spi_err), 8'h01);
    clr_spi();
    cmd(`ITM_OP_LAST + 4'h1);
    chk("op_err", 8'(spi_err), 8'h01);
    clr_spi();
    parity_check_en <= 1'b1;
    cmd(`ITM_OP_EXIT);
  endtask

  task automatic t_lock();
    cmd(`ITM_OP_ENTER_CFG);
    cmd(`ITM_OP_UNLOCK, `ITM_KEY_2);
    cmd(`ITM_OP_UNLOCK, `ITM_KEY_1);
    chk("key_order", 8'(test_unlocked), 8'h00);
    cmd(`ITM_OP_ENTER_VER);
    chk("ver_locked", 8'(op_mode), 8'(M_CFG));
    cmd(`ITM_OP_ENTER_ACT);
    cmd(`ITM_OP_UNLOCK, `ITM_KEY_1);
    cmd(`ITM_OP_UNLOCK, `ITM_KEY_2);
    cmd(`ITM_OP_ENTER_VER);
    cmd(`ITM_OP_ENTER_WK);
    chk("act_mode", 8'(op_mode), 8'(M_ACTIVE));
    chk("act_test", 8'(test_ctrl), 8'h00);
    host.set_pwm(1'b1);
    clk(4);
    chk("act_gate", 8'(gate), 8'h3E);
    host.set_pwm(1'b0);
    clk(4);
    cmd(`ITM_OP_EXIT);
  endtask

  task automatic t_sel();
    int n;
    for (int k = 0; k < 5; k++) begin
      unlock();
      cmd(`ITM_OP_WR_PSEL, {9'h000, PT[k]});
      cmd(`ITM_OP_WR_SSEL, {8'h00, ST[k]});
      chk("cfg_test", 8'(test_ctrl), 8'h00);
      cmd(`ITM_OP_ENTER_VER);
      chk("ver_mode", 8'(op_mode), 8'(M_VERIFY));
      chk("ver_test", 8'(test_ctrl), {3'h0, ET[k]});
      chk("ver_mon", 8'({gh_mon, os_mon}), 8'h00);
      // every entry must see the full count again
      wait_mode(M_OFF, n);
      chk("tmo", 8'(n >= TMO - 8 && n <= TMO), 8'h01);
    end
  endtask

  task automatic t_weak();
    logic [3:0] lvl;
    for (int v = 0; v < 2; v++) begin
      lvl = v[0] ? 4'hA : 4'h5;
      unlock();
      cmd(`ITM_OP_WR_PSEL);
      cmd(`ITM_OP_WR_SSEL);
      // no turn-off delay or plateau is programmed here
      cmd(`ITM_OP_WR_WEAK, {6'h00, v[0], lvl});
      cmd(`ITM_OP_ENTER_VER);
      cmd(`ITM_OP_ENTER_WK);
      chk("wk_mode", 8'(op_mode), 8'(M_WEAK));
      chk("wk_mon", 8'({gh_mon, os_mon}), 8'h00);
      host.set_pwm(1'b1);
      clk(4);
      chk("wk_gate", 8'(gate), 8'({1'b1, lvl, v[0]}));
      host.set_pwm(1'b0);
      clk(4);
      chk("wk_off", 8'(gate.on), 8'h00);
      cmd(`ITM_OP_EXIT);
    end
  endtask

  task automatic t_desat();
    int i;
    for (int k = 0; k < 2; k++) begin
      unlock();
      cmd(`ITM_OP_WR_SSEL, k[0] ? 11'(`ITM_SEC_DESAT2) : 11'(`ITM_SEC_DESAT1));
      cmd(`ITM_OP_ENTER_VER);
      cmd(`ITM_OP_ENTER_WK);
      desat_sense_above <= k[0];
      host.set_pwm(1'b1);
      clk(4);
      chk("ds_on", 8'(gate.on), 8'(!k[0]));
      chk("ds_blank", 8'(desat_err), 8'h00);
      for (i = 0; i < 4 * BLANK && desat_err !== 1'b1; i++) begin
        clk(1);
      end
      if (i == 4 * BLANK) begin
        err_count++;
        print_verdict();
      end
      clk(1);
      chk("ds_react", 8'(gate.on), 8'h00);
      host.set_pwm(1'b0);
      desat_sense_above <= 1'b0;
      // let the synchronised command drop, else a new hit beats the clear
      clk(4);
      desat_err_clr     <= 1'b1;
      clk(1);
      desat_err_clr <= 1'b0;
      clk(1);
      chk("ds_clr", 8'(desat_err), 8'h00);
      cmd(`ITM_OP_EXIT);
    end
  endtask

  task automatic t_rerst();
    rst_n <= 1'b0;
    clk(2);
    rst_n <= 1'b1;
    clk(3);
    chk("rerst_mode", 8'(op_mode), 8'(M_OFF));
    chk("rerst_unl", 8'(test_unlocked), 8'h00);
  endtask

  initial begin
    err_count = 0;
    num_checks = 0;
    rst_n             <= 1'b0;
    desat_sense_above <= 1'b0;
    uv                <= 1'b0;
    dok               <= 1'b1;
    parity_check_en   <= 1'b1;
    spi_err_clr       <= 1'b0;
    desat_err_clr     <= 1'b0;
    clk(3);
    rst_n <= 1'b1;
    clk(3);
    t_reset();
    t_notify();
    t_spi_err();
    t_lock();
    t_sel();
    t_rerst();
    t_weak();
    t_desat();
    print_verdict();
  end
endmodule
